// file: bench/lkh_host_model.sv
// Host processor model issuing legacy I/O cycles
`timescale 1ns/100ps
module lkh_host_model
(
	input logic clk,
	output logic io_write_strobe_n,
	output logic io_read_strobe_n,
	output logic [2:0] host_offset,
	output logic [7:0] host_wdata,
	input logic [7:0] host_rdata_r
);
	initial {io_write_strobe_n, io_read_strobe_n, host_offset, host_wdata} = 13'h1800;
	// One byte cycle; data shows its inverse once released
	task io(input logic w, input logic [2:0] o, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		{io_write_strobe_n, io_read_strobe_n} = {!w, w};
		host_offset = o;
		host_wdata = d;
		@(negedge clk);
		q = host_rdata_r;
		{io_write_strobe_n, io_read_strobe_n} = 2'h3;
		host_wdata = ~d;
	endtask
endmodule

// file: bench/lkh_host_port_checker.sv
// Concurrent checks on the host port boundary
`timescale 1ns/100ps
module lkh_host_port_checker
(
	input wire clk,
	input wire arst_n,
	input wire io_write_strobe_n,
	input wire io_read_strobe_n,
	input wire [2:0] host_offset,
	input wire [7:0] host_wdata,
	input wire [7:0] host_rdata_r,
	input wire cfg_wr,
	input wire cfg_ldn_match,
	input wire [7:0] cfg_index,
	input wire [7:0] cfg_wdata,
	input wire fw_wr,
	input wire fw_rd,
	input wire [11:0] fw_addr,
	input wire [7:0] fw_wdata,
	input wire kbc_reset_pulse_n,
	input wire host_cpu_reset_r,
	input wire input_full_irq_r,
	input wire primary_out_full_irq_r,
	input wire aux_out_full_irq_r
);
	reg act_r;
	wire wr = act_r && !io_write_strobe_n;
	wire rd = act_r && !io_read_strobe_n;
	wire cmd = wr && host_offset == 3'h4 && host_wdata < 8'hD1;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Shadow of the activate bit
	always @(posedge clk or negedge arst_n)
		if (!arst_n)
			act_r <= 1'b0;
		else if (cfg_wr && cfg_ldn_match && cfg_index == 8'h30)
			act_r <= cfg_wdata[0];
		else if (fw_wr && fw_addr == 12'h330)
			act_r <= fw_wdata[0];
	property p_nand; !kbc_reset_pulse_n |=> host_cpu_reset_r; endproperty
	a_nand: assert property (p_nand) else $error("reset out low");
	property p_cmd; cmd |=> input_full_irq_r; endproperty
	a_cmd: assert property (p_cmd) else $error("no ibf");
	property p_d1; wr && host_offset == 3'h4 && host_wdata == 8'hD1 && !input_full_irq_r
		|=> !input_full_irq_r; endproperty
	a_d1: assert property (p_d1) else $error("ibf on D1");
	property p_rdclr; rd && host_offset == 3'h0 && !fw_wr
		|=> !primary_out_full_irq_r && !aux_out_full_irq_r; endproperty
	a_rdclr: assert property (p_rdclr) else $error("irq kept");
	property p_fwclr; fw_rd && fw_addr == 12'h100 && !wr |=> !input_full_irq_r; endproperty
	a_fwclr: assert property (p_fwclr) else $error("ibf kept");
	property p_stat; rd && host_offset == 3'h4
		|=> host_rdata_r[1] == $past(input_full_irq_r) && (host_rdata_r & 8'hD4) == 8'h00;
	endproperty
	a_stat: assert property (p_stat) else $error("bad status");
	property p_off; !act_r && !input_full_irq_r |=> !input_full_irq_r; endproperty
	a_off: assert property (p_off) else $error("ibf while off");
	property p_cd; cmd ##1 io_write_strobe_n ##1 (rd && host_offset == 3'h4) |=> host_rdata_r[3];
	endproperty
	a_cd: assert property (p_cd) else $error("cd flag clear");
	c_cmd: cover property (cmd);
	c_rst: cover property ($rose(host_cpu_reset_r));
	c_rd: cover property (rd && host_offset == 3'h0);
endmodule
bind lkh_host_port lkh_host_port_checker i_chk (.clk, .arst_n, .io_write_strobe_n,
	.io_read_strobe_n, .host_offset, .host_wdata, .host_rdata_r, .cfg_wr, .cfg_ldn_match,
	.cfg_index, .cfg_wdata, .fw_wr, .fw_rd, .fw_addr, .fw_wdata, .kbc_reset_pulse_n,
	.host_cpu_reset_r, .input_full_irq_r, .primary_out_full_irq_r, .aux_out_full_irq_r);

// file: bench/tb_legacy_kbc_host_port.sv
// Self-checking bench for the legacy keyboard controller host port
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) \
	begin fails++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_legacy_kbc_host_port;
	localparam D = 4;
	localparam P = 4;
	logic clk = 0, arst_n = 0, slp = 0, kbc_n = 1;
	logic fw_wr = 0, fw_rd = 0, cfg_wr = 0, cfg_rd = 0, p92_wr = 0;
	logic [11:0] fa = 0;
	logic [7:0] wd = 0, b, g, rd, crd, frd;
	logic [7:0] sc [3] = '{8'hFF, 8'hFE, 8'hD1};
	wire wn, rn, rst_o, gate, input_full_flag, pirq, airq;
	wire [2:0] ofs;
	wire [7:0] hwd, hrd;
	int fails = 0, n_checks = 0, seed = 32'h0ef9, n, w;
	always #5 clk = ~clk;
	lkh_host_model i_host (.clk, .io_write_strobe_n(wn), .io_read_strobe_n(rn),
		.host_offset(ofs), .host_wdata(hwd), .host_rdata_r(hrd));
	lkh_host_port #(.TICK_DIV(D), .PULSE_TICKS(P)) i_dut (.clk, .arst_n,
		.system_domain_reset(1'b0), .kbc_sleep_request(slp), .io_write_strobe_n(wn),
		.io_read_strobe_n(rn), .host_offset(ofs), .host_wdata(hwd), .host_rdata_r(hrd),
		.cfg_wr, .cfg_rd, .cfg_ldn_match(1'b1), .cfg_index(fa[7:0]), .cfg_wdata(wd),
		.cfg_rdata_r(crd), .p92_wr, .p92_wdata(wd), .fw_wr, .fw_rd, .fw_addr(fa),
		.fw_wdata(wd), .fw_rdata_r(frd), .kbc_reset_pulse_n(kbc_n), .host_cpu_reset_r(rst_o),
		.addr20_gate_out_r(gate), .input_full_irq_r(input_full_flag), .primary_out_full_irq_r(pirq),
		.aux_out_full_irq_r(airq));
	// Kinds: 0 fw write, 1 fw read, 2 cfg write, 3 cfg read, 4 request port write
	task acc(input int k, input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		{fw_wr, fw_rd, cfg_wr, cfg_rd, p92_wr} = 5'h10 >> k;
		fa = a;
		wd = d;
		@(negedge clk);
		{fw_wr, fw_rd, cfg_wr, cfg_rd, p92_wr} = 5'h00;
		wd = ~d;
	endtask
	task hw(input logic [2:0] o, input logic [7:0] d);
		i_host.io(1'b1, o, d, rd);
	endtask
	task hr(input logic [2:0] o);
		i_host.io(1'b0, o, 8'h00, rd);
	endtask
	// Expected status byte from its flags
	function automatic logic [7:0] exp_status(input logic o, input logic i, input logic c,
		input logic a);
		exp_status = {2'h0, a, 1'b0, c, 1'b0, i, o};
	endfunction
	// Counts cycles of host reset high over a fixed window
	task pw;
		w = 0;
		repeat (40)
		begin
			@(negedge clk);
			w += rst_o;
		end
	endtask
	task final_report;
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		fails++;
		final_report;
	end
	initial
	begin
		repeat (10) @(negedge clk);
		arst_n = 1;
		hw(3'h4, 8'h20);
		`CHK("ibf off", 1'b0, input_full_flag)
		acc(2, 12'h030, 8'h01);
		acc(3, 12'h030, 8'h00);
		`CHK("cfg act", 8'h01, crd)
		acc(1, 12'h330, 8'h00);
		`CHK("fw act", 8'h01, frd)
		hr(3'h2);
		`CHK("unmapped", 8'h00, rd)
		repeat (8)
		begin
			b = $random(seed);
			n = b[0];
			if (n)
				b[7] = 1'b0;
			hw({n[0], 2'h0}, b);
			`CHK("ibf", 1'b1, input_full_flag)
			hr(3'h4);
			`CHK("status", exp_status(1'b0, 1'b1, n[0], 1'b0), rd)
			acc(1, 12'h100, 8'h00);
			`CHK("in byte", b, frd)
			`CHK("ibf clr", 1'b0, input_full_flag)
		end
		foreach (sc[i])
		begin
			hw(3'h4, sc[i]);
			`CHK("cmd ibf", 1'b0, input_full_flag)
		end
		repeat (2)
		begin
			b = $random(seed);
			b[1] = ~gate;
			hw(3'h4, 8'hD1);
			hw(3'h0, b);
			@(negedge clk);
			`CHK("gate", b[1], gate)
			`CHK("gate ibf", 1'b0, input_full_flag)
		end
		g = {6'h00, gate, 1'b0};
		hw(3'h0, ~g);
		@(negedge clk);
		`CHK("extra data", 1'b1, input_full_flag)
		`CHK("extra held", g[1], gate)
		acc(1, 12'h100, 8'h00);
		hw(3'h4, 8'hD1);
		hw(3'h4, 8'hA5);
		`CHK("bad seq", 1'b1, input_full_flag)
		hw(3'h4, 8'hFF);
		acc(1, 12'h100, 8'h00);
		hw(3'h0, ~g);
		@(negedge clk);
		`CHK("extra", 1'b1, input_full_flag)
		`CHK("gate held", g[1], gate)
		acc(0, 12'h108, {6'h00, 1'b1, ~g[1]});
		hw(3'h4, 8'hD1);
		hw(3'h0, ~g);
		@(negedge clk);
		`CHK("fw gate", ~g[1], gate)
		acc(0, 12'h108, 8'h00);
		@(negedge clk);
		`CHK("host gate", g[1], gate)
		b = $random(seed);
		acc(0, 12'h100, b);
		`CHK("obf irq", 1'b1, pirq)
		hr(3'h0);
		`CHK("out byte", b, rd)
		`CHK("irq clr", 2'h0, {pirq, airq})
		acc(0, 12'h10C, ~b);
		`CHK("aux irq", 1'b1, airq)
		hr(3'h4);
		`CHK("aux status", exp_status(1'b1, 1'b1, 1'b0, 1'b1), rd)
		hr(3'h0);
		`CHK("aux byte", ~b, rd)
		`CHK("aux clr", 2'h0, {pirq, airq})
		acc(4, 12'h000, 8'h01);
		pw;
		`CHK("width", 1'b1, w inside {[(P - 1) * D:P * D + 1]})
		acc(4, 12'h000, 8'h01);
		pw;
		`CHK("no rearm", 0, w)
		for (n = 0; n < 4; n++)
			acc(4, 12'h000, {7'h00, n[0]});
		pw;
		`CHK("rearm", 1'b1, w > 0)
		pw;
		`CHK("retrigger", 0, w)
		acc(4, 12'h000, 8'h00);
		acc(4, 12'h000, 8'h01);
		repeat (2) @(negedge clk);
		slp = 1;
		pw;
		`CHK("frozen", 40, w)
		slp = 0;
		pw;
		`CHK("ended", 1'b0, rst_o)
		kbc_n = 0;
		repeat (2) @(negedge clk);
		`CHK("kbc reset", 1'b1, rst_o)
		kbc_n = 1;
		final_report;
	end
endmodule

// file: include/lkh_regs.vh
// Offsets, field positions, command codes, reset values and timing for the host port
`ifndef LKH_REGS_VH
`define LKH_REGS_VH

// Host runtime offsets (host_offset port)
`define LKH_HOST_DATA_OFS 3'h0
`define LKH_HOST_CMD_OFS 3'h4

// Host configuration index of the power control register
`define LKH_CFG_ACTIVATE_IDX 8'h30

// Firmware offsets
`define LKH_FW_DATA_OFS 12'h100
`define LKH_FW_STATUS_OFS 12'h104
`define LKH_FW_CTRL_OFS 12'h108
`define LKH_FW_AUX_OFS 12'h10C
`define LKH_FW_ACTIVATE_OFS 12'h330

// Status byte fields
`define LKH_ST_OBF 0
`define LKH_ST_IBF 1
`define LKH_ST_CD 3
`define LKH_ST_AUX 5

// Firmware control byte fields
`define LKH_CTRL_FW_GATE 0
`define LKH_CTRL_OVERRIDE 1

// Power control byte fields
`define LKH_ACT_BIT 0
`define LKH_ACT_RESET 1'h0

// Port 92 request bit
`define LKH_P92_REQ_BIT 0

// Command codes
`define LKH_CMD_GATE 8'hD1
`define LKH_CMD_FE 8'hFE
`define LKH_CMD_FF 8'hFF

// Gate data bit
`define LKH_GATE_DATA_BIT 1

// Reset values
`define LKH_BYTE_RESET 8'h00

// Timing
`define LKH_CLK_NS 10
`define LKH_TICK_NS 1000
`define LKH_TICK_DIV (`LKH_TICK_NS / `LKH_CLK_NS)
`define LKH_ALT_PULSE_US 4
`define LKH_ALT_PULSE_TICKS (`LKH_ALT_PULSE_US * 1000 / `LKH_TICK_NS)

`endif

// file: rtl/lkh_alt_reset.v
// Alternate host reset pulse generator with re-arm on request release
`timescale 1ns/100ps
`include "lkh_regs.vh"

module lkh_alt_reset
#(
	parameter PULSE_TICKS = `LKH_ALT_PULSE_TICKS,
	parameter CW = 8
)
(
	input wire clk,
	input wire arst_n,
	input wire request,
	input wire tick,
	output reg alt_reset_pulse_n_r
);

	localparam integer LAST_I = PULSE_TICKS - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];

	reg armed_r;
	reg [CW-1:0] cnt_r;

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			armed_r <= 1'b0;
			cnt_r <= {CW{1'b0}};
			alt_reset_pulse_n_r <= 1'b1;
		end
		else if (!alt_reset_pulse_n_r)
		begin
			armed_r <= 1'b0; // R11
			if (tick)
			begin
				if (cnt_r == LAST)
					alt_reset_pulse_n_r <= 1'b1; // R22
				cnt_r <= cnt_r + 1'b1; // R22
			end
		end
		else if (!request)
			armed_r <= 1'b1; // R10
		else if (armed_r)
		begin
			armed_r <= 1'b0;
			cnt_r <= {CW{1'b0}};
			alt_reset_pulse_n_r <= 1'b0; // R8
		end
	end

endmodule

// file: rtl/lkh_gate_seq.v
// Address-20 gate command sequence decoder
`timescale 1ns/100ps
`include "lkh_regs.vh"

module lkh_gate_seq
(
	input wire clk,
	input wire arst_n,
	input wire sys_rst,
	input wire enable,
	input wire wr,
	input wire is_cmd,
	input wire [7:0] wdata,
	output reg suppress_ibf,
	output reg gate_load,
	output reg gate_val
);

	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_DATA = 2'b01;
	localparam [1:0] S_TRAIL = 2'b10;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg special;

	always @*
	begin
		state_nxt = state_r;
		suppress_ibf = 1'b0;
		gate_load = 1'b0;
		gate_val = wdata[`LKH_GATE_DATA_BIT]; // R4
		special = (wdata == `LKH_CMD_FF) || (wdata == `LKH_CMD_FE) || (wdata == `LKH_CMD_GATE);
		if (wr)
		begin
			if (is_cmd && special)
				suppress_ibf = 1'b1; // R5
			case (state_r)
				S_IDLE:
				begin
					if (is_cmd && wdata == `LKH_CMD_GATE)
						state_nxt = S_DATA;
				end
				S_DATA:
				begin
					if (!is_cmd)
					begin
						gate_load = 1'b1; // R20
						suppress_ibf = 1'b1; // R20
						state_nxt = S_TRAIL;
					end
					else if (wdata == `LKH_CMD_GATE)
						state_nxt = S_DATA; // R6
					else
					begin
						suppress_ibf = 1'b0; // R2
						state_nxt = S_IDLE; // R3
					end
				end
				S_TRAIL:
				begin
					if (is_cmd && wdata == `LKH_CMD_GATE)
						state_nxt = S_DATA;
					else
						state_nxt = S_IDLE; // R3
				end
				default:
					state_nxt = S_IDLE;
			endcase
		end
		if (!enable)
		begin
			gate_load = 1'b0; // R1
			state_nxt = S_IDLE;
		end
	end

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_r <= S_IDLE;
		else if (sys_rst)
			state_r <= S_IDLE;
		else
			state_r <= state_nxt;
	end

endmodule

// file: rtl/lkh_host_port.v
// Legacy keyboard controller host port with gate and alternate reset logic
`timescale 1ns/100ps
`include "lkh_regs.vh"

// What this block does
// R1: Gate decoding only while firmware override clear
// R2: Gate then other command: invalid, sets input-full
// R3: Unexpected byte returns gate sequencer to idle
// R4: Gate data byte uses only bit one
// R5: Commands FF, FE, D1 set no input-full, except FF or FE written right after D1
// R6: Repeated gate command keeps waiting for data
// R7: Gate output holds unless valid data arrives
// R8: Request bit set produces alternate reset pulse
// R9: Either reset pulse asserts host reset output
// R10: New pulse only after request returns zero
// R11: Clear-set during pulse gives no new pulse
// R12: 1MHz tick stops on sleep or inactive
// R13: Activate bit zero powers block down
// R14: Activate reachable at index 30h, offset 330h
// R15: Host data write: capture, data flag, input-full
// R16: Host command write: capture, command flag, input-full
// R17: Host read offset 0 returns output byte
// R18: Host read offset 4 returns status byte
// R19: Host data read clears output-full and interrupts
// R20: Gate data byte latches gate, no flags
// R21: Firmware input read clears input-full and interrupt
// R22: Alternate pulse width counted in 1MHz ticks
module lkh_host_port
#(
	parameter TICK_DIV = `LKH_TICK_DIV,
	parameter PULSE_TICKS = `LKH_ALT_PULSE_TICKS
)
(
	input wire clk,
	input wire arst_n,
	input wire system_domain_reset,
	input wire kbc_sleep_request,
	input wire io_write_strobe_n,
	input wire io_read_strobe_n,
	input wire [2:0] host_offset,
	input wire [7:0] host_wdata,
	output reg [7:0] host_rdata_r,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire cfg_ldn_match,
	input wire [7:0] cfg_index,
	input wire [7:0] cfg_wdata,
	output reg [7:0] cfg_rdata_r,
	input wire p92_wr,
	input wire [7:0] p92_wdata,
	input wire fw_wr,
	input wire fw_rd,
	input wire [11:0] fw_addr,
	input wire [7:0] fw_wdata,
	output reg [7:0] fw_rdata_r,
	input wire kbc_reset_pulse_n,
	output reg host_cpu_reset_r,
	output reg addr20_gate_out_r,
	output reg input_full_irq_r,
	output reg primary_out_full_irq_r,
	output reg aux_out_full_irq_r
);

	reg activate_r;
	reg override_r;
	reg fw_gate_r;
	reg host_gate_r;
	reg alt_host_reset_request_r;
	reg [7:0] in_byte_r;
	reg [7:0] out_byte_r;
	reg input_full_flag_r;
	reg output_full_flag_r;
	reg cmd_flag_r;
	reg aux_flag_r;
	reg [7:0] div_r;
	reg tick_r;
	reg [7:0] status;

	wire host_wr;
	wire host_rd;
	wire host_data_sel;
	wire host_cmd_sel;
	wire host_wr_data;
	wire host_wr_cmd;
	wire host_rd_data;
	wire fw_rd_data;
	wire fw_wr_data;
	wire fw_wr_aux;
	wire tick_run;
	wire suppress_ibf;
	wire gate_load;
	wire gate_val;
	wire alt_reset_pulse_n;
	wire cfg_act_sel;

	localparam integer DIV_LAST_I = TICK_DIV - 1;
	localparam [7:0] DIV_LAST = DIV_LAST_I[7:0];

	assign host_data_sel = (host_offset == `LKH_HOST_DATA_OFS);
	assign host_cmd_sel = (host_offset == `LKH_HOST_CMD_OFS);
	assign host_wr = !io_write_strobe_n && activate_r; // R13
	assign host_rd = !io_read_strobe_n && activate_r; // R13
	assign host_wr_data = host_wr && host_data_sel;
	assign host_wr_cmd = host_wr && host_cmd_sel;
	assign host_rd_data = host_rd && host_data_sel;
	assign fw_rd_data = fw_rd && (fw_addr == `LKH_FW_DATA_OFS);
	assign fw_wr_data = fw_wr && (fw_addr == `LKH_FW_DATA_OFS);
	assign fw_wr_aux = fw_wr && (fw_addr == `LKH_FW_AUX_OFS);
	assign cfg_act_sel = cfg_ldn_match && (cfg_index == `LKH_CFG_ACTIVATE_IDX);
	assign tick_run = activate_r && !kbc_sleep_request;

	// Status byte as seen by host and firmware
	always @*
	begin
		status = `LKH_BYTE_RESET;
		status[`LKH_ST_OBF] = output_full_flag_r;
		status[`LKH_ST_IBF] = input_full_flag_r;
		status[`LKH_ST_CD] = cmd_flag_r;
		status[`LKH_ST_AUX] = aux_flag_r;
	end

	lkh_gate_seq u_gate_seq
	(
		.clk(clk),
		.arst_n(arst_n),
		.sys_rst(system_domain_reset),
		.enable(!override_r),
		.wr(host_wr_data || host_wr_cmd),
		.is_cmd(host_wr_cmd),
		.wdata(host_wdata),
		.suppress_ibf(suppress_ibf),
		.gate_load(gate_load),
		.gate_val(gate_val)
	);

	lkh_alt_reset #(.PULSE_TICKS(PULSE_TICKS), .CW(8)) u_alt_reset
	(
		.clk(clk),
		.arst_n(arst_n),
		.request(alt_host_reset_request_r),
		.tick(tick_r),
		.alt_reset_pulse_n_r(alt_reset_pulse_n)
	);

	// 1MHz tick from the system clock
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_r <= 8'h00;
			tick_r <= 1'b0;
		end
		else if (!tick_run)
		begin
			div_r <= 8'h00; // R12
			tick_r <= 1'b0; // R12
		end
		else if (div_r == DIV_LAST)
		begin
			div_r <= 8'h00;
			tick_r <= 1'b1;
		end
		else
		begin
			div_r <= div_r + 8'h01;
			tick_r <= 1'b0;
		end
	end

	// Power control and port 92 request, main-power reset only
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			activate_r <= `LKH_ACT_RESET; // R13
			alt_host_reset_request_r <= 1'b0;
		end
		else
		begin
			if (cfg_wr && cfg_act_sel)
				activate_r <= cfg_wdata[`LKH_ACT_BIT]; // R14
			else if (fw_wr && fw_addr == `LKH_FW_ACTIVATE_OFS)
				activate_r <= fw_wdata[`LKH_ACT_BIT]; // R14
			if (p92_wr)
				alt_host_reset_request_r <= p92_wdata[`LKH_P92_REQ_BIT]; // R10
		end
	end

	// Host and firmware data path
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			in_byte_r <= `LKH_BYTE_RESET;
			out_byte_r <= `LKH_BYTE_RESET;
			input_full_flag_r <= 1'b0;
			output_full_flag_r <= 1'b0;
			cmd_flag_r <= 1'b0;
			aux_flag_r <= 1'b0;
			primary_out_full_irq_r <= 1'b0;
			aux_out_full_irq_r <= 1'b0;
			input_full_irq_r <= 1'b0;
			override_r <= 1'b0;
			fw_gate_r <= 1'b0;
			host_gate_r <= 1'b0;
		end
		else if (system_domain_reset)
		begin
			in_byte_r <= `LKH_BYTE_RESET;
			out_byte_r <= `LKH_BYTE_RESET;
			input_full_flag_r <= 1'b0;
			output_full_flag_r <= 1'b0;
			cmd_flag_r <= 1'b0;
			aux_flag_r <= 1'b0;
			primary_out_full_irq_r <= 1'b0;
			aux_out_full_irq_r <= 1'b0;
			input_full_irq_r <= 1'b0;
			override_r <= 1'b0;
			fw_gate_r <= 1'b0;
			host_gate_r <= 1'b0;
		end
		else
		begin
			if (host_wr_data || host_wr_cmd)
			begin
				in_byte_r <= host_wdata; // R15
				cmd_flag_r <= host_wr_cmd; // R16
			end
			if ((host_wr_data || host_wr_cmd) && !suppress_ibf)
			begin
				input_full_flag_r <= 1'b1; // R15
				input_full_irq_r <= 1'b1; // R16
			end
			else if (fw_rd_data)
			begin
				input_full_flag_r <= 1'b0; // R21
				input_full_irq_r <= 1'b0; // R21
			end
			if (gate_load)
				host_gate_r <= gate_val; // R7
			if (fw_wr_data || fw_wr_aux)
			begin
				out_byte_r <= fw_wdata;
				output_full_flag_r <= 1'b1;
				aux_flag_r <= fw_wr_aux;
				primary_out_full_irq_r <= fw_wr_data;
				aux_out_full_irq_r <= fw_wr_aux;
			end
			else if (host_rd_data)
			begin
				output_full_flag_r <= 1'b0; // R19
				primary_out_full_irq_r <= 1'b0; // R19
				aux_out_full_irq_r <= 1'b0; // R19
			end
			if (fw_wr && fw_addr == `LKH_FW_CTRL_OFS)
			begin
				override_r <= fw_wdata[`LKH_CTRL_OVERRIDE];
				fw_gate_r <= fw_wdata[`LKH_CTRL_FW_GATE];
			end
		end
	end

	// Registered outputs and read data
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_rdata_r <= `LKH_BYTE_RESET;
			cfg_rdata_r <= `LKH_BYTE_RESET;
			fw_rdata_r <= `LKH_BYTE_RESET;
			host_cpu_reset_r <= 1'b0;
			addr20_gate_out_r <= 1'b0;
		end
		else
		begin
			host_cpu_reset_r <= !(alt_reset_pulse_n && kbc_reset_pulse_n); // R9
			addr20_gate_out_r <= override_r ? fw_gate_r : host_gate_r; // R1
			if (host_rd)
			begin
				if (host_data_sel)
					host_rdata_r <= out_byte_r; // R17
				else if (host_cmd_sel)
					host_rdata_r <= status; // R18
				else
					host_rdata_r <= `LKH_BYTE_RESET;
			end
			if (cfg_rd)
				cfg_rdata_r <= cfg_act_sel ? {7'h00, activate_r} : `LKH_BYTE_RESET; // R14
			if (fw_rd)
			begin
				case (fw_addr)
					`LKH_FW_DATA_OFS:
						fw_rdata_r <= in_byte_r;
					`LKH_FW_STATUS_OFS:
						fw_rdata_r <= status;
					`LKH_FW_CTRL_OFS:
						fw_rdata_r <= {6'h00, override_r, addr20_gate_out_r};
					`LKH_FW_AUX_OFS:
						fw_rdata_r <= out_byte_r;
					`LKH_FW_ACTIVATE_OFS:
						fw_rdata_r <= {7'h00, activate_r}; // R13
					default:
						fw_rdata_r <= `LKH_BYTE_RESET;
				endcase
			end
		end
	end

endmodule
